// ---- src/rail_cfg_pkg.sv ----
`default_nettype none
package rail_cfg_pkg;

    // Timebase
    localparam int CLK_MHZ = 100;

    // Line timing, in the units shown, and the cycle counts derived from them
    localparam int STORE_MIN_US = 30;
    localparam int OFF_MIN_US = 30;
    localparam int NEG_DELAY_MS = 10;
    localparam int TRIP_MS = 1;
    localparam int STORE_CYC = STORE_MIN_US * CLK_MHZ;
    localparam int OFF_CYC = OFF_MIN_US * CLK_MHZ;
    localparam int NEG_DELAY_CYC = NEG_DELAY_MS * 1000 * CLK_MHZ;
    localparam int TRIP_CYC = TRIP_MS * 1000 * CLK_MHZ;
    localparam int LINE_CNT_W = 12;

    // Pulse count table boundaries
    localparam logic [6:0] NEG_FIRST = 7'h01;
    localparam logic [6:0] NEG_LAST = 7'h33;
    localparam logic [6:0] ANA_FIRST = 7'h34;
    localparam logic [6:0] ANA_LAST = 7'h4f;
    localparam logic [6:0] DIS_ON = 7'h50;
    localparam logic [6:0] DIS_OFF = 7'h51;
    localparam logic [6:0] DET_ON = 7'h52;
    localparam logic [6:0] DET_OFF = 7'h53;
    localparam logic [6:0] POS_FIRST = 7'h54;
    localparam logic [6:0] POS_LAST = 7'h5a;
    localparam logic [6:0] PLIM_FIRST = 7'h5b;
    localparam logic [6:0] PLIM_LAST = 7'h61;
    localparam logic [6:0] ALIM_FIRST = 7'h62;
    localparam logic [6:0] ALIM_LAST = 7'h68;
    localparam logic [6:0] COUNT_MAX = 7'h7f;

    // Setting codes: step index from the first entry of each range
    localparam logic [5:0] NEG_DEFAULT = 6'h18;
    localparam logic [4:0] ANA_DEFAULT = 5'h08;
    localparam logic [2:0] POS_DEFAULT = 3'h0;
    localparam logic [2:0] PLIM_DEFAULT = 3'h6;
    localparam logic [2:0] ALIM_DEFAULT = 3'h4;

    // Register map (byte addresses)
    localparam int ADR_W = 8;
    localparam logic [7:0] SETTINGS_ADR = 8'h00;
    localparam logic [7:0] STATUS_ADR = 8'h04;
    localparam logic [7:0] COMMAND_ADR = 8'h08;

    // Settings word fields
    localparam int NEG_LSB = 0;
    localparam int ANA_LSB = 8;
    localparam int POS_LSB = 16;
    localparam int PLIM_LSB = 20;
    localparam int ALIM_LSB = 24;
    localparam int DET_BIT = 28;
    localparam int DIS_LSB = 29;

    // Status word fields
    localparam int ST_POS_EN = 0;
    localparam int ST_NEG_EN = 1;
    localparam int ST_ANA_EN = 2;
    localparam int ST_TRIP = 3;
    localparam int ST_SENSE = 4;
    localparam int ST_HS_OFF = 5;
    localparam int ST_DISCH = 6;
    localparam int ST_LINE = 7;
    localparam int ST_COUNT_LSB = 8;

    typedef enum logic [1:0] {
        DIS_FOLLOW_PIN = 2'h0,
        DIS_FORCE_ON = 2'h1,
        DIS_FORCE_OFF = 2'h2
    } dis_mode_t;

    typedef enum logic [3:0] {
        SEQ_IDLE = 4'h1,
        SEQ_POS_ON = 4'h2,
        SEQ_BOTH_ON = 4'h4,
        SEQ_TRIPPED = 4'h8
    } seq_state_t;

endpackage : rail_cfg_pkg
`default_nettype wire

// ---- src/pin_sync.sv ----
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;

    // Only the second stage leaves this module
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_o <= '0;
        end else begin
            meta_reg <= pin_i;
            sync_o <= meta_reg;
        end
    end

endmodule : pin_sync
`default_nettype wire

// ---- src/rail_configurator.sv ----
// Behaviour
// - Rising edges on the control line are counted; the count picks item and value.
// - Counts 1-51 set negative rail, 52-79 set analog rail, 0.1V steps.
// - Counts 84-90 set positive rail 4.6V-5.2V; default 4.6V.
// - Counts 91-97 positive limit, 98-104 analog limit; defaults 650mA and 210mA.
// - 250mV detection defaults off; count 82 turns on, 83 off.
// - By default discharge follows the discharge select pin.
// - Count 80 forces discharge on, 81 forces it off despite the pin.
// - Line high starts positive rail; negative rail follows 10ms later.
// - Power cycle returns every setting to default.
// - Long low on the line resets positive and negative rail settings.
// - Auxiliary enable switches the analog rail independently of the line.
// - Auxiliary enable and line both low reset analog rail and all settings.
// - Positive overcurrent lasting 1ms shuts down until line reset or power cycle.
// - Sense at output pin when remote sense is off or far; remote when close.
// - Input near positive rail disables the high side switch.
// - Line held high 30-80us after last pulse; count is latched then.
// - Line low 30-80us is a shutdown period clearing panel rail settings.
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`default_nettype none
module rail_configurator
    import rail_cfg_pkg::*;
#(
    parameter int NEG_DELAY = NEG_DELAY_CYC,
    parameter int TRIP_DELAY = TRIP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic pulse_ctrl_i,
    input wire logic aux_enable_i,
    input wire logic discharge_select_pin_i,
    input wire logic pos_over_limit_i,
    input wire logic remote_sense_open_i,
    input wire logic remote_sense_far_i,
    input wire logic remote_sense_near_i,
    input wire logic vin_near_pos_i,
    output logic [5:0] neg_code_o,
    output logic [4:0] ana_code_o,
    output logic [2:0] pos_code_o,
    output logic [2:0] pos_limit_code_o,
    output logic [2:0] ana_limit_code_o,
    output logic detect_250_o,
    output logic discharge_o,
    output logic pos_enable_o,
    output logic neg_enable_o,
    output logic ana_enable_o,
    output logic overcurrent_trip_o,
    output logic remote_sense_select_o,
    output logic high_side_switch_off_o
);
    localparam int NEG_W = $clog2(NEG_DELAY + 1);
    localparam int TRIP_W = $clog2(TRIP_DELAY + 1);

    function automatic logic in_range(input logic [6:0] n, input logic [6:0] lo, input logic [6:0] hi);
        in_range = (n >= lo) && (n <= hi);
    endfunction : in_range

    logic [7:0] pin_raw;
    logic [7:0] pin_s;
    logic line_s;
    logic aux_s;
    logic dsel_s;
    logic over_s;
    logic open_s;
    logic far_s;
    logic near_s;
    logic vin_s;
    logic line_d_reg;
    logic line_rise;
    logic [6:0] count_reg;
    logic [LINE_CNT_W-1:0] high_cnt_reg;
    logic [LINE_CNT_W-1:0] low_cnt_reg;
    logic latch_evt;
    logic off_evt;
    logic low_long;
    logic full_clear;
    logic apply_evt;
    logic [6:0] apply_count;
    logic cmd_evt;
    logic [6:0] cmd_reg;
    logic det_reg;
    dis_mode_t dis_mode_reg;
    seq_state_t state_reg;
    seq_state_t state_next;
    logic [NEG_W-1:0] neg_cnt_reg;
    logic [TRIP_W-1:0] trip_cnt_reg;
    logic neg_due;
    logic trip_due;
    logic bus_req;
    logic [31:0] settings_word;
    logic [31:0] status_word;

    assign pin_raw = {vin_near_pos_i, remote_sense_near_i, remote_sense_far_i, remote_sense_open_i,
                      pos_over_limit_i, discharge_select_pin_i, aux_enable_i, pulse_ctrl_i};

    pin_sync #(
        .WIDTH(8)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pin_raw),
        .sync_o(pin_s)
    );

    assign line_s = pin_s[0];
    assign aux_s = pin_s[1];
    assign dsel_s = pin_s[2];
    assign over_s = pin_s[3];
    assign open_s = pin_s[4];
    assign far_s = pin_s[5];
    assign near_s = pin_s[6];
    assign vin_s = pin_s[7];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_d_reg <= 1'b0;
        end else begin
            line_d_reg <= line_s;
        end
    end

    assign line_rise = line_s && !line_d_reg;

    // store timer, armed only while a burst is pending
    always_ff @(posedge clk_i) begin
        if (rst_i || !line_s || count_reg == 7'h00) begin
            high_cnt_reg <= '0;
        end else if (high_cnt_reg != LINE_CNT_W'(STORE_CYC)) begin
            high_cnt_reg <= high_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || line_s) begin
            low_cnt_reg <= '0;
        end else if (low_cnt_reg != LINE_CNT_W'(OFF_CYC)) begin
            low_cnt_reg <= low_cnt_reg + 1'b1;
        end
    end

    assign latch_evt = line_s && (high_cnt_reg == LINE_CNT_W'(STORE_CYC - 1)) && (count_reg != 7'h00);
    assign off_evt = !line_s && (low_cnt_reg == LINE_CNT_W'(OFF_CYC - 1));
    assign low_long = low_cnt_reg == LINE_CNT_W'(OFF_CYC);
    // both low for a full shutdown period; pulse lows keep settings
    assign full_clear = low_long && !aux_s;

    always_ff @(posedge clk_i) begin
        if (rst_i || off_evt) begin
            count_reg <= 7'h00;
        end else if (latch_evt) begin
            count_reg <= 7'h00;
        end else if (line_rise && count_reg != COUNT_MAX) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // A command write acts as a latched burst
    assign cmd_evt = bus_req && !wb_ack_o && wb_we_i && wb_sel_i[0] && (wb_adr_i == COMMAND_ADR);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_reg <= 7'h00;
        end else if (cmd_evt) begin
            cmd_reg <= wb_dat_i[6:0];
        end
    end

    assign apply_evt = latch_evt || cmd_evt;
    assign apply_count = latch_evt ? count_reg : wb_dat_i[6:0];

    always_ff @(posedge clk_i) begin
        if (rst_i || off_evt || full_clear) begin
            neg_code_o <= NEG_DEFAULT;
        end else if (apply_evt && in_range(apply_count, NEG_FIRST, NEG_LAST)) begin
            neg_code_o <= 6'(apply_count - NEG_FIRST);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || full_clear) begin
            ana_code_o <= ANA_DEFAULT;
        end else if (apply_evt && in_range(apply_count, ANA_FIRST, ANA_LAST)) begin
            ana_code_o <= 5'(apply_count - ANA_FIRST);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || off_evt || full_clear) begin
            pos_code_o <= POS_DEFAULT;
        end else if (apply_evt && in_range(apply_count, POS_FIRST, POS_LAST)) begin
            pos_code_o <= 3'(apply_count - POS_FIRST);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || full_clear) begin
            pos_limit_code_o <= PLIM_DEFAULT;
            ana_limit_code_o <= ALIM_DEFAULT;
        end else if (apply_evt) begin
            if (in_range(apply_count, PLIM_FIRST, PLIM_LAST)) begin
                pos_limit_code_o <= 3'(apply_count - PLIM_FIRST);
            end
            if (in_range(apply_count, ALIM_FIRST, ALIM_LAST)) begin
                ana_limit_code_o <= 3'(apply_count - ALIM_FIRST);
            end
        end
    end

    // detection option; other counts fall through untouched
    always_ff @(posedge clk_i) begin
        if (rst_i || full_clear) begin
            det_reg <= 1'b0;
        end else if (apply_evt && apply_count == DET_ON) begin
            det_reg <= 1'b1;
        end else if (apply_evt && apply_count == DET_OFF) begin
            det_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || full_clear) begin
            dis_mode_reg <= DIS_FOLLOW_PIN;
        end else if (apply_evt && apply_count == DIS_ON) begin
            dis_mode_reg <= DIS_FORCE_ON;
        end else if (apply_evt && apply_count == DIS_OFF) begin
            dis_mode_reg <= DIS_FORCE_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            detect_250_o <= 1'b0;
            discharge_o <= 1'b0;
        end else begin
            detect_250_o <= det_reg;
            unique case (dis_mode_reg)
                DIS_FORCE_ON: discharge_o <= 1'b1;
                DIS_FORCE_OFF: discharge_o <= 1'b0;
                default: discharge_o <= dsel_s;
            endcase
        end
    end

    // overcurrent timer, runs only while the positive rail is on
    always_ff @(posedge clk_i) begin
        if (rst_i || !over_s || !(state_reg == SEQ_POS_ON || state_reg == SEQ_BOTH_ON)) begin
            trip_cnt_reg <= '0;
        end else if (!trip_due) begin
            trip_cnt_reg <= trip_cnt_reg + 1'b1;
        end
    end

    assign trip_due = trip_cnt_reg == TRIP_W'(TRIP_DELAY);

    always_ff @(posedge clk_i) begin
        if (rst_i || state_reg != SEQ_POS_ON) begin
            neg_cnt_reg <= '0;
        end else if (!neg_due) begin
            neg_cnt_reg <= neg_cnt_reg + 1'b1;
        end
    end

    assign neg_due = neg_cnt_reg == NEG_W'(NEG_DELAY - 1);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SEQ_IDLE: begin
                if (line_rise) begin
                    state_next = SEQ_POS_ON;
                end
            end
            SEQ_POS_ON: begin
                if (trip_due) begin
                    state_next = SEQ_TRIPPED;
                end else if (off_evt) begin
                    state_next = SEQ_IDLE;
                end else if (neg_due) begin
                    state_next = SEQ_BOTH_ON;
                end
            end
            SEQ_BOTH_ON: begin
                if (trip_due) begin
                    state_next = SEQ_TRIPPED;
                end else if (off_evt) begin
                    state_next = SEQ_IDLE;
                end
            end
            SEQ_TRIPPED: begin
                // released by a line reset only
                if (off_evt) begin
                    state_next = SEQ_IDLE;
                end
            end
            default: state_next = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= SEQ_IDLE;
            pos_enable_o <= 1'b0;
            neg_enable_o <= 1'b0;
            overcurrent_trip_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            pos_enable_o <= (state_next == SEQ_POS_ON) || (state_next == SEQ_BOTH_ON);
            neg_enable_o <= state_next == SEQ_BOTH_ON;
            overcurrent_trip_o <= state_next == SEQ_TRIPPED;
        end
    end

    // analog rail follows its own enable; a trip shuts all three rails
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ana_enable_o <= 1'b0;
        end else begin
            ana_enable_o <= aux_s && (state_next != SEQ_TRIPPED);
        end
    end

    // sense select holds between the two thresholds
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            remote_sense_select_o <= 1'b0;
        end else if (open_s || far_s) begin
            remote_sense_select_o <= 1'b0;
        end else if (near_s) begin
            remote_sense_select_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_side_switch_off_o <= 1'b0;
        end else begin
            high_side_switch_off_o <= vin_s;
        end
    end

    // Bus slave: one wait state, every address answers
    assign bus_req = wb_cyc_i && wb_stb_i;

    always_comb begin
        settings_word = '0;
        settings_word[NEG_LSB +: 6] = neg_code_o;
        settings_word[ANA_LSB +: 5] = ana_code_o;
        settings_word[POS_LSB +: 3] = pos_code_o;
        settings_word[PLIM_LSB +: 3] = pos_limit_code_o;
        settings_word[ALIM_LSB +: 3] = ana_limit_code_o;
        settings_word[DET_BIT] = det_reg;
        settings_word[DIS_LSB +: 2] = dis_mode_reg;
    end

    always_comb begin
        status_word = '0;
        status_word[ST_POS_EN] = pos_enable_o;
        status_word[ST_NEG_EN] = neg_enable_o;
        status_word[ST_ANA_EN] = ana_enable_o;
        status_word[ST_TRIP] = overcurrent_trip_o;
        status_word[ST_SENSE] = remote_sense_select_o;
        status_word[ST_HS_OFF] = high_side_switch_off_o;
        status_word[ST_DISCH] = discharge_o;
        status_word[ST_LINE] = line_s;
        status_word[ST_COUNT_LSB +: 7] = count_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            if (bus_req && !wb_ack_o && !wb_we_i) begin
                unique case (wb_adr_i)
                    SETTINGS_ADR: wb_dat_o <= settings_word;
                    STATUS_ADR: wb_dat_o <= status_word;
                    COMMAND_ADR: wb_dat_o <= {25'h0, cmd_reg};
                    default: wb_dat_o <= '0;
                endcase
            end else begin
                wb_dat_o <= '0;
            end
        end
    end

endmodule : rail_configurator
`default_nettype wire

// ---- verif/rail_cfg_chk.sv ----
`default_nettype none
module rail_cfg_chk
    import rail_cfg_pkg::*;
#(
    parameter int NEG_DELAY = NEG_DELAY_CYC,
    parameter int TRIP_DELAY = TRIP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pulse_ctrl_i,
    input wire logic aux_enable_i,
    input wire logic pos_over_limit_i,
    input wire logic remote_sense_open_i,
    input wire logic remote_sense_far_i,
    input wire logic remote_sense_near_i,
    input wire logic vin_near_pos_i,
    input wire logic [5:0] neg_code_o,
    input wire logic [2:0] pos_code_o,
    input wire logic pos_enable_o,
    input wire logic neg_enable_o,
    input wire logic ana_enable_o,
    input wire logic overcurrent_trip_o,
    input wire logic remote_sense_select_o,
    input wire logic high_side_switch_off_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rst_d;
    always_ff @(posedge clk_i) rst_d <= rst_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || rst_d);
    int neg_cnt;
    int over_cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i || !pos_enable_o) begin
            neg_cnt <= 0;
        end else if (!neg_enable_o) begin
            neg_cnt <= neg_cnt + 1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || !pos_over_limit_i) begin
            over_cnt <= 0;
        end else if (over_cnt < TRIP_DELAY + 8) begin
            over_cnt <= over_cnt + 1;
        end
    end
    chk_neg_on_time: assert property ($rose(neg_enable_o) |-> neg_cnt >= NEG_DELAY - 1 && neg_cnt <= NEG_DELAY + 1)
        else $error("negative rail enabled at the wrong delay");
    chk_neg_late: assert property (pos_enable_o |-> neg_cnt <= NEG_DELAY + 1)
        else $error("negative rail enable overdue");
    chk_neg_after_pos: assert property (neg_enable_o |-> pos_enable_o)
        else $error("negative rail on without positive rail");
    chk_start_defaults: assert property ($rose(pos_enable_o) |-> pos_code_o == POS_DEFAULT && neg_code_o == NEG_DEFAULT)
        else $error("panel rails not started at default codes");
    chk_trip_all_off: assert property (overcurrent_trip_o |-> !pos_enable_o && !neg_enable_o && !ana_enable_o)
        else $error("rail enabled while tripped");
    chk_trip_cause: assert property ($rose(overcurrent_trip_o) |-> over_cnt >= TRIP_DELAY)
        else $error("trip without sustained overcurrent");
    chk_trip_holds: assert property (overcurrent_trip_o && pulse_ctrl_i |=> overcurrent_trip_o)
        else $error("trip released while line high");
    chk_sense_local: assert property ((remote_sense_open_i || remote_sense_far_i) [*4] |-> !remote_sense_select_o)
        else $error("remote sense kept while open or far");
    chk_sense_remote: assert property ((remote_sense_near_i && !remote_sense_open_i && !remote_sense_far_i) [*4]
        |-> remote_sense_select_o)
        else $error("remote sense not chosen when near");
    chk_diode_mode: assert property (vin_near_pos_i [*4] |-> high_side_switch_off_o)
        else $error("high side switch left on near input");
    chk_aux_off: assert property (!aux_enable_i [*4] |-> !ana_enable_o)
        else $error("analog rail on with aux low");
    chk_aux_on: assert property ((aux_enable_i && !overcurrent_trip_o) [*5] |-> ana_enable_o)
        else $error("analog rail off with aux high");
endmodule : rail_cfg_chk
bind rail_configurator rail_cfg_chk #(.NEG_DELAY(NEG_DELAY), .TRIP_DELAY(TRIP_DELAY)) rail_cfg_chk_i (
    .clk_i(clk_i), .rst_i(rst_i), .pulse_ctrl_i(pulse_ctrl_i), .aux_enable_i(aux_enable_i),
    .pos_over_limit_i(pos_over_limit_i), .remote_sense_open_i(remote_sense_open_i),
    .remote_sense_far_i(remote_sense_far_i), .remote_sense_near_i(remote_sense_near_i),
    .vin_near_pos_i(vin_near_pos_i), .neg_code_o(neg_code_o), .pos_code_o(pos_code_o),
    .pos_enable_o(pos_enable_o), .neg_enable_o(neg_enable_o), .ana_enable_o(ana_enable_o),
    .overcurrent_trip_o(overcurrent_trip_o), .remote_sense_select_o(remote_sense_select_o),
    .high_side_switch_off_o(high_side_switch_off_o));
`default_nettype wire

// ---- verif/host_line_model.sv ----
`default_nettype none
module host_line_model (
    input wire logic clk_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_o = 1'b0;
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_cyc
    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            // high and low times of 2us
            if (line_o) begin
                line_o <= 1'b0;
                wait_cyc(200);
            end
            line_o <= 1'b1;
            wait_cyc(200);
        end
        // store period of 35us after the last rise
        wait_cyc(3300);
    endtask : burst
    task automatic hold_low();
        line_o <= 1'b0;
        wait_cyc(4000);
    endtask : hold_low
endmodule : host_line_model
`default_nettype wire

// ---- verif/pulse_count_rail_configurator_test.sv ----
`default_nettype none
module pulse_count_rail_configurator_test;
    import rail_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NEG_D = 50;
    localparam int TRIP_D = 20;
    localparam logic [31:0] DEF_WORD = 32'(NEG_DEFAULT) | (32'(ANA_DEFAULT) << ANA_LSB) | (32'(POS_DEFAULT) << POS_LSB)
        | (32'(PLIM_DEFAULT) << PLIM_LSB) | (32'(ALIM_DEFAULT) << ALIM_LSB);
    logic clk_i, rst_i, wb_we, wb_cyc, wb_stb, wb_ack, line, aux, dpin, over, s_open, s_far, s_near, vin_near;
    logic det, disch, pos_en, neg_en, ana_en, trip, sense_sel, hs_off;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat, rdata;
    logic [5:0] neg_code;
    logic [4:0] ana_code;
    logic [2:0] pos_code, plim_code, alim_code;
    int fails = 0;
    int n_tests = 0;
    int e_neg, e_ana, e_pos, e_plim, e_alim, e_det, e_dm;
    int cmds[15] = '{51, 52, 79, 84, 90, 91, 97, 98, 104, 82, 83, 105, 0, 81, 80};
    rail_configurator #(.NEG_DELAY(NEG_D), .TRIP_DELAY(TRIP_D)) rail_configurator_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel), .wb_we_i(wb_we),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .pulse_ctrl_i(line),
        .aux_enable_i(aux), .discharge_select_pin_i(dpin), .pos_over_limit_i(over), .remote_sense_open_i(s_open),
        .remote_sense_far_i(s_far), .remote_sense_near_i(s_near), .vin_near_pos_i(vin_near), .neg_code_o(neg_code),
        .ana_code_o(ana_code), .pos_code_o(pos_code), .pos_limit_code_o(plim_code), .ana_limit_code_o(alim_code),
        .detect_250_o(det), .discharge_o(disch), .pos_enable_o(pos_en), .neg_enable_o(neg_en),
        .ana_enable_o(ana_en), .overcurrent_trip_o(trip), .remote_sense_select_o(sense_sel),
        .high_side_switch_off_o(hs_off));
    host_line_model host_line_model_i (.clk_i(clk_i), .line_o(line));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_cyc
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        rdata = wb_rdat;
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
    endtask : wb_xfer
    task automatic reset_exp();
        {e_neg, e_ana, e_pos} = {32'(NEG_DEFAULT), 32'(ANA_DEFAULT), 32'(POS_DEFAULT)};
        {e_plim, e_alim, e_det, e_dm} = {32'(PLIM_DEFAULT), 32'(ALIM_DEFAULT), 32'h0, 32'h0};
    endtask : reset_exp
    task automatic chk_all();
        chk("neg_code", 32'(e_neg), 32'(neg_code));
        chk("ana_code", 32'(e_ana), 32'(ana_code));
        chk("pos_code", 32'(e_pos), 32'(pos_code));
        chk("pos_limit", 32'(e_plim), 32'(plim_code));
        chk("ana_limit", 32'(e_alim), 32'(alim_code));
        chk("detect", 32'(e_det), 32'(det));
        chk("discharge", (e_dm == 0) ? 32'(dpin) : 32'(e_dm == 1), 32'(disch));
    endtask : chk_all
    initial begin
        {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} = {4'h8, 8'h00, 32'h0, 4'hf};
        {aux, dpin, over, s_open, s_far, s_near, vin_near} = 7'b1101000;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_exp();
        wait_cyc(5);
        chk_all();
        wb_xfer(1'b1, SETTINGS_ADR, 32'hffff_ffff);
        wb_xfer(1'b0, SETTINGS_ADR, 32'h0);
        chk("settings", DEF_WORD, rdata);
        wb_xfer(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h0, rdata);
        chk("sense_open", 32'h0, 32'(sense_sel));
        {s_open, s_near} <= 2'b01;
        wait_cyc(6);
        chk("sense_near", 32'h1, 32'(sense_sel));
        {s_near, s_far, vin_near} <= 3'b011;
        wait_cyc(6);
        chk("sense_far", 32'h0, 32'(sense_sel));
        chk("diode_mode", 32'h1, 32'(hs_off));
        host_line_model_i.burst(3);
        chk("pos_en", 32'h1, 32'(pos_en));
        chk("neg_en", 32'h1, 32'(neg_en));
        e_neg = 2;
        chk_all();
        wb_xfer(1'b0, STATUS_ADR, 32'h0);
        chk("pending", 32'h0, 32'(rdata[14:8]));
        host_line_model_i.burst(2);
        e_neg = 1;
        chk_all();
        foreach (cmds[i]) begin
            if (cmds[i] >= 1 && cmds[i] <= 51) e_neg = cmds[i] - 1;
            else if (cmds[i] >= 52 && cmds[i] <= 79) e_ana = cmds[i] - 52;
            else if (cmds[i] == 80 || cmds[i] == 81) e_dm = cmds[i] - 79;
            else if (cmds[i] == 82 || cmds[i] == 83) e_det = 83 - cmds[i];
            else if (cmds[i] >= 84 && cmds[i] <= 90) e_pos = cmds[i] - 84;
            else if (cmds[i] >= 91 && cmds[i] <= 97) e_plim = cmds[i] - 91;
            else if (cmds[i] >= 98 && cmds[i] <= 104) e_alim = cmds[i] - 98;
            wb_xfer(1'b1, COMMAND_ADR, 32'(cmds[i]));
            wait_cyc(3);
            chk_all();
        end
        dpin <= 1'b0;
        wait_cyc(5);
        chk_all();
        host_line_model_i.hold_low();
        {e_neg, e_pos} = {32'(NEG_DEFAULT), 32'(POS_DEFAULT)};
        chk_all();
        chk("pos_off", 32'h0, 32'({pos_en, neg_en}));
        chk("ana_on", 32'h1, 32'(ana_en));
        aux <= 1'b0;
        wait_cyc(4000);
        reset_exp();
        chk_all();
        chk("ana_off", 32'h0, 32'(ana_en));
        aux <= 1'b1;
        host_line_model_i.burst(1);
        over <= 1'b1;
        wait_cyc(TRIP_D / 2);
        over <= 1'b0;
        wait_cyc(5);
        chk("short_over", 32'h0, 32'(trip));
        over <= 1'b1;
        wait_cyc(TRIP_D + 10);
        over <= 1'b0;
        wait_cyc(10);
        chk("trip", 32'h2, 32'({trip, pos_en}));
        host_line_model_i.hold_low();
        chk("trip_clear", 32'h0, 32'(trip));
        wb_xfer(1'b1, COMMAND_ADR, 32'h5a);
        wb_xfer(1'b0, COMMAND_ADR, 32'h0);
        chk("command", 32'h5a, 32'(rdata[6:0]));
        rst_i <= 1'b1;
        wait_cyc(2);
        rst_i <= 1'b0;
        wb_xfer(1'b0, SETTINGS_ADR, 32'h0);
        chk("settings_reset", DEF_WORD, rdata);
        stop_test();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        fails++;
        stop_test();
    end
endmodule : pulse_count_rail_configurator_test
`default_nettype wire
